// ### pbi_pkg.sv
/*
   pbi_pkg: constants, state codes and shared helpers of the bus pin
   interface (32-bit multiplexed address/data bus, master and target).
   assumes: every user runs on the one bus clock; network logic that
   consumes the user ports lives in its own clock domain elsewhere.
*/
package pbi_pkg;

   ////////////////////////////////////////////////////////////////////////
   // bus clock range in MHz; all logic is static, so a stopped clock
   // only freezes state and loses nothing
   localparam int BUS_FMIN_MHZ  = 10;
   localparam int BUS_FMAX_MHZ  = 33;
   localparam int BUS_FSTOP_MHZ = 0;
   localparam int CLK_PERIOD_NS = 25;

   ////////////////////////////////////////////////////////////////////////
   // bus commands as they appear on the command lanes
   localparam logic [3:0] CMD_MEM_RD  = 4'h6;
   localparam logic [3:0] CMD_MEM_WR  = 4'h7;
   localparam logic [3:0] CMD_CFG_RD  = 4'hA;
   localparam logic [3:0] CMD_CFG_WR  = 4'hB;
   localparam logic [3:0] CMD_MEM_RDM = 4'hC;
   localparam logic [3:0] CMD_MEM_RDL = 4'hE;
   localparam logic [3:0] CMD_MEM_WRI = 4'hF;

   ////////////////////////////////////////////////////////////////////////
   // field positions, counts and values after reset
   localparam int         BAR_LSB    = 8;     // target window: 256 bytes
   localparam logic [1:0] ADDR_LOW   = 2'h0;  // linear burst order
   localparam logic [2:0] MABORT_CYC = 3'h5;  // clocks without a claim
   localparam logic [31:0] AD_RST    = 32'h0;
   localparam logic [3:0]  CBE_RST   = 4'hF;
   localparam logic [31:0] PARK_AD   = 32'h0;
   localparam logic [3:0]  PARK_CBE  = 4'h0;
   localparam int          NT_W      = 44;    // pins in the test chain

   ////////////////////////////////////////////////////////////////////////
   // sequencer states
   typedef enum logic [3:0] {
      S_IDLE  = 4'h0,  // monitor, request or park
      S_MADDR = 4'h1,  // master address phase
      S_MDATA = 4'h2,  // master data phase
      S_MLOAD = 4'h3,  // master wait, next word loads
      S_MABT  = 4'h4,  // master closing after stop or abort
      S_MEND  = 4'h5,  // master release
      S_TWR   = 4'h6,  // target write phase
      S_TRDL  = 4'h7,  // target read turnaround, data loads
      S_TRD   = 4'h8,  // target read phase
      S_TFIN  = 4'h9   // target waits for end of frame
   } pbi_state_t;

   ////////////////////////////////////////////////////////////////////////
   // byte order reversal of one word
   function automatic logic [31:0] pbi_swap32(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction: pbi_swap32

   // even parity over address/data and command lanes
   function automatic logic pbi_par(input logic [31:0] ad,
                                    input logic [3:0]  cbe);
      return ^{ad, cbe};
   endfunction: pbi_par

   // cascaded nand chain over the test inputs
   function automatic logic pbi_nand_chain(input logic [NT_W-1:0] v);
      logic t;
      t = ~v[0];
      for (int i = 1; i < NT_W; i++) begin
         t = ~(v[i] & t);
      end
      return t;
   endfunction: pbi_nand_chain

endpackage: pbi_pkg

// ### pbi_sts.sv
/*
   pbi_sts: driver of one active-low sustained tri-state pin.
   assumes: act_in is the next asserted state, from bus-clock logic.
*/
`timescale 1ns/100ps
module pbi_sts (
   input  wire logic clk_in,   // bus clock
   input  wire logic rst_in,   // synchronous reset, active high
   input  wire logic act_in,   // assert the pin next cycle
   output logic      n_out,    // pin level, active low
   output logic      oe_out    // pin driven
);
   import pbi_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // low while active, then one high cycle, then float
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         n_out  <= 1'b1;
         oe_out <= 1'b0;
      end else begin
         n_out  <= ~act_in;
         oe_out <= act_in | ~n_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sts_high_once_a: assert property ((oe_out && n_out) |=>
      (!oe_out || !n_out)) else $error("high drive over one cycle");
   sts_release_a: assert property ($fell(oe_out) |->
      $past(n_out) && $past(oe_out, 2) && !$past(n_out, 2))
      else $error("released without high cycle");

endmodule: pbi_sts

// ### pbi_top.sv
/*
   pbi_top: 32-bit multiplexed bus pin interface, master and target.
   assumes: all pins are synchronous to clk_in, the bus clock; two-way
   pins are split into in/out/oe and resolved outside; network logic on
   the user ports sits in a separate clock domain behind its own crossing.
*/
// Behaviour
// - release active-low pin after one high cycle
// - first clock address, later clocks data
// - little endian byte lanes by default
// - byte swap reverses fifo data only
// - master address has low bits zero
// - monitor bus for target hits when idle
// - drive master writes, target reads; latch others
// - command in address phase, enables after
// - byte enables stay on physical lanes
// - sample all pins on rising clock edge
// - network logic uses another clock domain
// - static logic, bus clock 10-33 MHz, stoppable
// - claim own hits, watch claim as master
// - frame held until final data phase
// - target finds address phase from frame
// - park lanes on grant without request
// - config cycles need chip select asserted
// - reset turns pins into test chain inputs
// - phase completes with both ready signals
// - parity even over lanes and commands
`timescale 1ns/100ps
module pbi_top (
   input  wire logic                           clk_in,
   input  wire logic                           rst_in,
   // bus pins
   input  wire logic [31:0]                    ad_in,
   output logic      [31:0]                    ad_out,
   output logic                                ad_oe_out,
   input  wire logic [3:0]                     cbe_n_in,
   output logic      [3:0]                     cbe_n_out,
   output logic                                cbe_oe_out,
   input  wire logic                           par_in,
   output logic                                par_out,
   output logic                                par_oe_out,
   input  wire logic                           frame_n_in,
   output logic                                frame_n_out,
   output logic                                frame_oe_out,
   input  wire logic                           irdy_n_in,
   output logic                                irdy_n_out,
   output logic                                irdy_oe_out,
   input  wire logic                           trdy_n_in,
   output logic                                trdy_n_out,
   output logic                                trdy_oe_out,
   input  wire logic                           devsel_n_in,
   output logic                                devsel_n_out,
   output logic                                devsel_oe_out,
   input  wire logic                           stop_n_in,
   output logic                                stop_n_out,
   output logic                                stop_oe_out,
   input  wire logic                           gnt_n_in,
   input  wire logic                           idsel_in,
   output logic                                req_n_out,
   output logic                                nand_tree_out,
   // configuration
   input  wire logic                           byte_swap_enable_in,
   input  wire logic [31-pbi_pkg::BAR_LSB:0]   tgt_bar_in,
   // master user side; its consumer runs on another clock
   input  wire logic                           mst_req_in,
   input  wire logic [3:0]                     mst_cmd_in,
   input  wire logic [29:0]                    mst_addr_in,
   input  wire logic                           mst_fifo_in,
   input  wire logic [31:0]                    mst_wdata_in,
   input  wire logic [3:0]                     mst_wbe_n_in,
   input  wire logic                           mst_last_in,
   output logic                                mst_ack_out,
   output logic      [31:0]                    mst_rdata_out,
   output logic                                mst_done_out,
   output logic                                mst_abort_out,
   output logic                                mst_stop_out,
   // target user side
   output logic                                tgt_rd_out,
   output logic                                tgt_wr_out,
   output logic                                tgt_cfg_out,
   output logic      [31:0]                    tgt_addr_out,
   output logic      [31:0]                    tgt_wdata_out,
   output logic      [3:0]                     tgt_be_n_out,
   input  wire logic [31:0]                    tgt_rdata_in
);
   import pbi_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state and decode
   pbi_state_t state_r;       // sequencer state
   pbi_state_t state_nxt;     // its next value
   logic       frame_prev_r;  // frame level one clock ago
   logic       wr_r;          // master cycle is a write
   logic       fifo_r;        // master cycle moves fifo data
   logic       claimed_r;     // a target claimed our cycle
   logic [2:0] dsel_cnt_r;    // clocks waited for a claim
   logic       frame_act;     // next-cycle assert requests
   logic       irdy_act;
   logic       trdy_act;
   logic       devsel_act;
   logic       stop_act;
   logic       bus_idle;
   logic       start;
   logic       addr_ph;
   logic       hit_mem;
   logic       hit_cfg;
   logic       tgt_hit;
   logic       done;
   logic       abort;
   logic       swap_on;
   logic [3:0] cbe_bus;       // command lanes as seen on the bus

   // decode of the bus in the current cycle
   assign bus_idle = frame_n_in & irdy_n_in;
   assign start    = (state_r == S_IDLE) && mst_req_in && !gnt_n_in
                     && bus_idle;
   // only a falling frame marks an address phase
   assign addr_ph  = (state_r == S_IDLE) && frame_prev_r
                     && !frame_n_in;
   assign hit_mem  = (cbe_n_in == CMD_MEM_RD || cbe_n_in == CMD_MEM_WR ||
                      cbe_n_in == CMD_MEM_RDM || cbe_n_in == CMD_MEM_RDL ||
                      cbe_n_in == CMD_MEM_WRI)
                     && (ad_in[31:BAR_LSB] == tgt_bar_in);
   assign hit_cfg  = (cbe_n_in == CMD_CFG_RD || cbe_n_in == CMD_CFG_WR)
                     && idsel_in && (ad_in[1:0] == ADDR_LOW);
   assign tgt_hit  = addr_ph && (hit_mem || hit_cfg);
   assign done     = !irdy_n_in && !trdy_n_in;
   assign abort    = (state_r == S_MDATA) && !claimed_r && devsel_n_in
                     && (dsel_cnt_r == MABORT_CYC);
   assign swap_on  = byte_swap_enable_in && fifo_r;
   assign cbe_bus  = cbe_oe_out ? cbe_n_out : cbe_n_in;

   ////////////////////////////////////////////////////////////////////////
   // sequencer: next state and next control pin assertions
   always_comb begin
      state_nxt  = state_r;
      frame_act  = 1'b0;
      irdy_act   = 1'b0;
      trdy_act   = 1'b0;
      devsel_act = 1'b0;
      stop_act   = 1'b0;
      unique case (state_r)
         S_IDLE: begin
            if (start) begin
               // frame opens the address phase
               state_nxt = S_MADDR;
               frame_act = 1'b1;
            end else if (tgt_hit) begin
               devsel_act = 1'b1;
               if (cbe_n_in[0]) begin
                  // write: ready at once, one phase then disconnect
                  state_nxt = S_TWR;
                  trdy_act  = 1'b1;
                  stop_act  = 1'b1;
               end else begin
                  state_nxt = S_TRDL;
               end
            end
         end
         S_MADDR, S_MLOAD: begin
            // frame drops before the final phase
            state_nxt = S_MDATA;
            frame_act = ~mst_last_in;
            irdy_act  = 1'b1;
         end
         S_MDATA: begin
            irdy_act  = 1'b1;
            frame_act = ~frame_n_out;
            if (done && !frame_n_out && stop_n_in) begin
               // burst goes on, wait one clock for the next word
               state_nxt = S_MLOAD;
               frame_act = 1'b1;
               irdy_act  = 1'b0;
            end else if (done || !stop_n_in || abort) begin
               // last phase, target stop or no claim: close
               frame_act = 1'b0;
               irdy_act  = ~frame_n_out;
               state_nxt = frame_n_out ? S_MEND : S_MABT;
            end
         end
         S_MABT: begin
            state_nxt = S_MEND;
         end
         S_MEND: begin
            state_nxt = S_IDLE;
         end
         S_TWR, S_TRD: begin
            devsel_act = 1'b1;
            trdy_act   = 1'b1;
            stop_act   = 1'b1;
            if (done) begin
               trdy_act  = 1'b0;
               // hold stop and devsel until frame ends
               devsel_act = ~frame_n_in;
               stop_act   = ~frame_n_in;
               state_nxt  = frame_n_in ? S_IDLE : S_TFIN;
            end
         end
         S_TRDL: begin
            state_nxt  = S_TRD;
            devsel_act = 1'b1;
            trdy_act   = 1'b1;
            stop_act   = 1'b1;
         end
         S_TFIN: begin
            devsel_act = ~frame_n_in;
            stop_act   = ~frame_n_in;
            if (frame_n_in) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // state register; every pin is sampled on this rising edge
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_r      <= S_IDLE;
         frame_prev_r <= 1'b1;
      end else begin
         state_r      <= state_nxt;
         frame_prev_r <= frame_n_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // master cycle attributes and claim timeout
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_r       <= 1'b0;
         fifo_r     <= 1'b0;
         claimed_r  <= 1'b0;
         dsel_cnt_r <= 3'h0;
      end else begin
         if (start) begin
            wr_r   <= mst_cmd_in[0];
            fifo_r <= mst_fifo_in;
         end
         if (state_r == S_IDLE) begin
            claimed_r  <= 1'b0;
            dsel_cnt_r <= 3'h0;
         end else if (!devsel_n_in) begin
            claimed_r <= 1'b1;
         end else if (dsel_cnt_r != MABORT_CYC) begin
            dsel_cnt_r <= dsel_cnt_r + 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address/data and command lanes
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ad_out     <= AD_RST;
         ad_oe_out  <= 1'b0;
         cbe_n_out  <= CBE_RST;
         cbe_oe_out <= 1'b0;
      end else if (start) begin
         // address phase: dword address, command on the lanes
         ad_out     <= {mst_addr_in, ADDR_LOW};
         ad_oe_out  <= 1'b1;
         cbe_n_out  <= mst_cmd_in;
         cbe_oe_out <= 1'b1;
      end else if (state_r == S_IDLE && !gnt_n_in && bus_idle) begin
         // parked: grant without request
         ad_out     <= PARK_AD;
         ad_oe_out  <= 1'b1;
         cbe_n_out  <= PARK_CBE;
         cbe_oe_out <= 1'b1;
      end else if (state_r == S_MADDR || state_r == S_MLOAD) begin
         // data phase: only writes drive data; enables never swap
         if (wr_r) begin
            ad_out <= swap_on ? pbi_swap32(mst_wdata_in)
                              : mst_wdata_in;
         end
         ad_oe_out  <= wr_r;
         cbe_n_out  <= mst_wbe_n_in;
      end else if (state_r == S_TRDL) begin
         ad_out     <= tgt_rdata_in;
         ad_oe_out  <= 1'b1;
      end else if (state_nxt == S_MEND || state_r == S_IDLE ||
                   (state_r == S_TRD && done)) begin
         ad_oe_out  <= 1'b0;
         cbe_oe_out <= 1'b0;
      end
   end

   // parity follows the lanes it covers by one clock
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         par_out    <= 1'b0;
         par_oe_out <= 1'b0;
      end else begin
         par_out    <= pbi_par(ad_out, cbe_bus);
         par_oe_out <= ad_oe_out;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sustained tri-state control pins
   pbi_sts u_frame (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .act_in (frame_act),
      .n_out  (frame_n_out),
      .oe_out (frame_oe_out)
   );
   pbi_sts u_irdy (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .act_in (irdy_act),
      .n_out  (irdy_n_out),
      .oe_out (irdy_oe_out)
   );
   pbi_sts u_trdy (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .act_in (trdy_act),
      .n_out  (trdy_n_out),
      .oe_out (trdy_oe_out)
   );
   pbi_sts u_devsel (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .act_in (devsel_act),
      .n_out  (devsel_n_out),
      .oe_out (devsel_oe_out)
   );
   pbi_sts u_stop (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .act_in (stop_act),
      .n_out  (stop_n_out),
      .oe_out (stop_oe_out)
   );

   ////////////////////////////////////////////////////////////////////////
   // request and test chain
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         req_n_out <= 1'b1;
      end else begin
         req_n_out <= ~(mst_req_in && state_r == S_IDLE && !start);
      end
   end

   // in reset the pins feed the nand chain, otherwise it rests low
   always_ff @(posedge clk_in) begin
      nand_tree_out <= rst_in & pbi_nand_chain({ad_in, cbe_n_in, par_in,
         frame_n_in, irdy_n_in, trdy_n_in, devsel_n_in, stop_n_in,
         gnt_n_in, idsel_in});
   end

   ////////////////////////////////////////////////////////////////////////
   // master user answers
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         mst_ack_out   <= 1'b0;
         mst_rdata_out <= AD_RST;
         mst_done_out  <= 1'b0;
         mst_abort_out <= 1'b0;
         mst_stop_out  <= 1'b0;
      end else begin
         mst_ack_out   <= (state_r == S_MDATA) && done;
         if (state_r == S_MDATA && done && !wr_r) begin
            mst_rdata_out <= swap_on ? pbi_swap32(ad_in) : ad_in;
         end
         mst_done_out  <= (state_r != S_MEND) && (state_nxt == S_MEND);
         mst_abort_out <= abort;
         mst_stop_out  <= (state_r == S_MDATA) && !stop_n_in;
      end
   end

   // target user strobes
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tgt_rd_out    <= 1'b0;
         tgt_wr_out    <= 1'b0;
         tgt_cfg_out   <= 1'b0;
         tgt_addr_out  <= AD_RST;
         tgt_wdata_out <= AD_RST;
         tgt_be_n_out  <= CBE_RST;
      end else begin
         tgt_rd_out <= tgt_hit && !cbe_n_in[0];
         tgt_wr_out <= (state_r == S_TWR) && done;
         if (tgt_hit) begin
            tgt_addr_out <= ad_in;
            tgt_cfg_out  <= hit_cfg;
         end
         if (state_r == S_TWR && done) begin
            tgt_wdata_out <= ad_in;
            tgt_be_n_out  <= cbe_n_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   addr_low_a: assert property (state_r == S_MADDR |->
      ad_oe_out && ad_out[1:0] == ADDR_LOW && !frame_n_out)
      else $error("address phase low bits not zero");
   start_idle_a: assert property ($rose(state_r == S_MADDR) |->
      $past(!gnt_n_in && frame_n_in && irdy_n_in))
      else $error("master started without idle grant");
   be_fixed_a: assert property ((state_r == S_MDATA &&
      $past(state_r) != S_MDATA) |-> cbe_n_out == $past(mst_wbe_n_in))
      else $error("byte enables moved");
   swap_data_a: assert property ((state_r == S_MDATA && wr_r &&
      $past(state_r) != S_MDATA) |-> ad_out == ($past(swap_on) ?
      pbi_swap32($past(mst_wdata_in)) : $past(mst_wdata_in)))
      else $error("write data byte order wrong");
   par_even_a: assert property (par_oe_out |->
      par_out == ^{$past(ad_out), $past(cbe_bus)})
      else $error("parity not even");
   park_drive_a: assert property ((state_r == S_IDLE && !gnt_n_in &&
      bus_idle && !mst_req_in) |=> ad_oe_out && cbe_oe_out ##1 par_oe_out)
      else $error("bus not parked");
   cfg_select_a: assert property ((addr_ph && !idsel_in &&
      !hit_mem) |=> devsel_n_out) else $error("claimed unselected cycle");
   ack_ready_a: assert property (mst_ack_out |->
      $past(!irdy_n_in && !trdy_n_in)) else $error("ack without ready");
   last_phase_a: assert property ((state_r == S_MDATA &&
      frame_n_out) |-> !irdy_n_out && irdy_oe_out)
      else $error("frame dropped without irdy");
   abort_time_a: assert property ($rose(state_r == S_MADDR) ##1
      (devsel_n_in && state_r == S_MDATA && stop_n_in && !done)[*5]
      |=> mst_abort_out) else $error("no master abort");
   rst_float_a: assert property (@(posedge clk_in) disable iff (1'b0)
      rst_in |=> !ad_oe_out && !cbe_oe_out && !frame_oe_out)
      else $error("pins driven in reset");

   mst_wr_c: cover property (mst_done_out && wr_r && !mst_abort_out);
   mst_rd_c: cover property (mst_ack_out && !wr_r);
   tgt_wr_c: cover property (tgt_wr_out);
   tgt_rd_c: cover property ((state_r == S_TRD) && done);
   park_c:   cover property (ad_oe_out && state_r == S_IDLE);

endmodule: pbi_top

// ### pbi_far_tgt.sv
/* pbi_far_tgt: far-side target that claims frames while enabled.
   assumes: released control lines float high through pull-ups. */
`timescale 1ns/100ps
module pbi_far_tgt (
   input  wire logic        clk_in,
   input  wire logic        en_in,        // claim frames
   input  wire logic        slow_in,      // one wait before ready
   input  wire logic        frame_n_in,
   input  wire logic        irdy_n_in,
   input  wire logic [31:0] ad_in,
   output logic             devsel_n_out,
   output logic             trdy_n_out,
   output logic      [31:0] data_out      // last word taken
);
   logic fr_r;  // frame level at last edge
   initial begin
      devsel_n_out = 1'b1;
      trdy_n_out = 1'b1;
      fr_r = 1'b1;
   end
   // claim on frame fall, take data when both ready, then release
   always @(posedge clk_in) begin
      fr_r <= frame_n_in;
      if (en_in && fr_r && !frame_n_in) begin
         devsel_n_out <= #2 1'b0;
         trdy_n_out <= #2 slow_in;
      end else if (!devsel_n_out && trdy_n_out) begin
         trdy_n_out <= #2 1'b0;
      end else if (!trdy_n_out && !irdy_n_in) begin
         data_out <= ad_in;
         devsel_n_out <= #2 1'b1;
         trdy_n_out <= #2 1'b1;
      end
   end
endmodule: pbi_far_tgt

// ### pbi_top_tb.sv
/* pbi_top_tb: master, target and parking scenarios of pbi_top.
   assumes: pbi_far_tgt answers master cycles; bench acts as initiator. */
`timescale 1ns/100ps
module pbi_top_tb;
   import pbi_pkg::*;
   logic clk_in, rst_in, gnt_n_in, idsel_in, byte_swap_enable_in, mst_req_in,
      mst_fifo_in, mst_last_in, tb_drv, tb_frame, tb_irdy, m_en, m_slow, h,
      ad_oe_out, cbe_oe_out, par_out, par_oe_out, frame_n_out, frame_oe_out,
      irdy_n_out, irdy_oe_out, trdy_n_out, trdy_oe_out, devsel_n_out,
      devsel_oe_out, stop_n_out, stop_oe_out, req_n_out, nand_tree_out,
      mst_ack_out, mst_done_out, mst_abort_out, mst_stop_out, tgt_rd_out,
      tgt_wr_out, tgt_cfg_out, m_devsel, m_trdy;
   logic [3:0] mst_cmd_in, mst_wbe_n_in, tb_cbe, cbe_n_out, tgt_be_n_out;
   logic [31:0] mst_wdata_in, tgt_rdata_in, tb_ad, tb_rd, ad_out,
      mst_rdata_out, tgt_addr_out, tgt_wdata_out, m_data;
   logic [29:0] mst_addr_in;
   logic [23:0] tgt_bar_in;
   int n_errors = 0, check_count = 0;
   // resolved bus lines; a released data bus shows the inverse value
   wire [31:0] ad_in = ad_oe_out ? ad_out : tb_drv ? tb_ad : ~tb_ad;
   wire [3:0] cbe_n_in = cbe_oe_out ? cbe_n_out : tb_cbe;
   wire par_in = par_oe_out ? par_out : 1'b1;
   wire frame_n_in = frame_oe_out ? frame_n_out : tb_frame;
   wire irdy_n_in = irdy_oe_out ? irdy_n_out : tb_irdy;
   wire trdy_n_in = trdy_oe_out ? trdy_n_out : m_trdy;
   wire devsel_n_in = devsel_oe_out ? devsel_n_out : m_devsel;
   wire stop_n_in = stop_oe_out ? stop_n_out : 1'b1;
   pbi_top pbi_top_inst (.*);
   pbi_far_tgt pbi_far_tgt_inst (.clk_in(clk_in), .en_in(m_en),
      .slow_in(m_slow), .frame_n_in(frame_n_in), .irdy_n_in(irdy_n_in),
      .ad_in(ad_in), .devsel_n_out(m_devsel), .trdy_n_out(m_trdy),
      .data_out(m_data));
   initial begin
      clk_in = 0;
      forever #12.5 clk_in = ~clk_in;
   end
   task chk(input logic ok, input string m);
      check_count++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("Error %0t: %s", $time, m);
      end
   endtask: chk
   task print_verdict;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask: print_verdict
   task mst_wr(input logic sw, input logic [31:0] ex);
      int k;
      @(posedge clk_in); #2;
      m_en = 1; m_slow = sw; mst_fifo_in = sw; mst_req_in = 1; k = 0;
      repeat (3) @(posedge clk_in); #2;
      chk(req_n_out === 1'b0 && frame_oe_out === 1'b0, "start");
      gnt_n_in = 0;
      while (frame_n_in !== 1'b0 && k < 9) begin
         @(posedge clk_in); #2; k++;
      end
      chk(ad_out === 32'h100 && cbe_n_out === CMD_MEM_WR, "addr");
      while (mst_done_out !== 1'b1 && k < 19) begin
         @(posedge clk_in); #2; k++;
      end
      chk(m_data === ex && mst_ack_out === 1'b1, "data");
      chk(irdy_oe_out === 1'b1 && irdy_n_out === 1'b1, "irdy high");
      @(posedge clk_in); #2;
      chk(irdy_oe_out === 1'b0, "irdy float");
      mst_req_in = 0; gnt_n_in = 1; m_en = 0;
   endtask: mst_wr
   task mst_abt;
      int k;
      @(posedge clk_in); #2;
      mst_req_in = 1; gnt_n_in = 0; k = 0;
      while (mst_abort_out !== 1'b1 && k < 12) begin
         @(posedge clk_in); #2; k++;
      end
      chk(k == MABORT_CYC + 2 && mst_done_out === 1'b1, "abort");
      @(posedge clk_in); #2;
      mst_req_in = 0; gnt_n_in = 1;
   endtask: mst_abt
   task tb_cyc(input logic [3:0] c, input logic [31:0] a, input logic [3:0] b);
      int k;
      @(posedge clk_in); #2;
      tb_frame = 0; tb_ad = a; tb_cbe = c; tb_drv = 1; k = 0;
      @(posedge clk_in); #2;
      tb_frame = 1; tb_irdy = 0; tb_ad = 32'h1122_3344; tb_cbe = b;
      tb_drv = c[0];
      while (trdy_n_in !== 1'b0 && k < 6) begin @(posedge clk_in); #2; k++; end
      tb_rd = ad_in; h = k < 6;
      @(posedge clk_in); #2;
      tb_irdy = 1; tb_drv = 0; tb_cbe = 4'hF;
   endtask: tb_cyc
   task tgt_seq;
      tb_cyc(CMD_MEM_WR, 32'hA5C3_0010, 4'h5);
      chk(h && tgt_wr_out === 1'b1 && tgt_wdata_out === 32'h1122_3344
         && tgt_be_n_out === 4'h5, "tgt wr");
      tb_cyc(CMD_MEM_RD, 32'hA5C3_0020, 4'h0);
      chk(h && tb_rd === tgt_rdata_in && tgt_addr_out === 32'hA5C3_0020,
         "tgt rd");
      tb_cyc(CMD_MEM_WR, 32'h1234_0000, 4'h0);
      chk(!h, "bar miss");
      tb_cyc(CMD_CFG_RD, 32'h40, 4'h0);
      chk(!h, "cfg no sel");
      idsel_in = 1;
      tb_cyc(CMD_CFG_RD, 32'h40, 4'h0);
      chk(h && tgt_cfg_out === 1'b1, "cfg sel");
   endtask: tgt_seq
   initial begin
      rst_in = 1; gnt_n_in = 1; idsel_in = 1; byte_swap_enable_in = 1;
      mst_req_in = 0; mst_fifo_in = 0; mst_last_in = 1; tb_drv = 0;
      tb_frame = 1; tb_irdy = 1; m_en = 0; m_slow = 0; tb_cbe = 4'hF;
      tb_ad = 0; mst_cmd_in = CMD_MEM_WR; mst_wbe_n_in = 4'h0;
      mst_wdata_in = 32'h1122_3344; tgt_rdata_in = 32'hC0DE_5A17;
      mst_addr_in = 30'h40; tgt_bar_in = 24'hA5C300;
      repeat (11) @(posedge clk_in); #2;
      chk(nand_tree_out === 1'b1 && ad_oe_out === 1'b0, "nand tree");
      @(posedge clk_in); #2;
      rst_in = 0;
      idsel_in = 0;
      gnt_n_in = 0;
      repeat (3) @(posedge clk_in); #2;
      chk(ad_oe_out === 1'b1 && ad_out === PARK_AD
         && cbe_n_out === PARK_CBE, "park");
      gnt_n_in = 1;
      repeat (3) @(posedge clk_in); #2;
      mst_wr(1'b0, 32'h1122_3344);
      mst_wr(1'b1, 32'h4433_2211);
      mst_abt();
      tgt_seq();
      print_verdict();
   end
   initial begin
      #20000;
      n_errors++;
      print_verdict();
   end
endmodule: pbi_top_tb
